// ---- hw/pms_pkg.sv ----
package pms_pkg;
   localparam int CLK_MHZ = 100;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_WAKE_EN = 8'h04;
   localparam logic [7:0] OFS_WAKE_CAUSE = 8'h08;
   localparam logic [7:0] OFS_RESET_CAUSE = 8'h0C;
   localparam logic [7:0] OFS_DEEP_CAUSE = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // control field positions
   localparam int CTRL_BACKUP = 0;
   localparam int CTRL_HOLD_LOGIC = 1;
   localparam int CTRL_QUICK_WAKE = 2;
   localparam int CTRL_SLOW_SEL = 3;
   localparam int CTRL_WAKE_CLK = 4;
   localparam int CTRL_LEVEL_LO = 5;
   localparam int CTRL_SCALE_REQ = 7;
   localparam int CTRL_SLEEP_LO = 8;
   localparam int CTRL_XTAL32_EN = 10;
   localparam int CTRL_RC32_EN = 11;
   localparam int CTRL_IRQ_EN = 12;
   localparam int CTRL_W = 13;
   localparam logic [12:0] CTRL_RESET = 13'h0000;
   // wake cause bits: 0 ext irq lines, 1 calendar timer, 7 power ok
   localparam int WAKE_W = 8;
   localparam logic [7:0] WAKE_EXEMPT = 8'h03;
   localparam int WAKE_POWER_OK_FLAG = 7;
   localparam int RSTC_BACKUP = 4;
   localparam int RST_W = 4;
   localparam int BKW_W = 5;
   localparam int BKW_EXT_LINES = 0;
   localparam logic [1:0] LEVEL_DEFAULT = 2'h0;
   localparam logic [1:0] SLEEP_SRC_STOP = 2'h3;
   // clock source restart and regulator settle times
   localparam int SRC_WAKE_NS = 1000;
   localparam int SETTLE_NS = 2000;
   localparam int SRC_WAKE_CYC = (SRC_WAKE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 12;

   typedef enum logic [2:0] {
      PMS_RUN = 3'b000,
      PMS_SLEEP = 3'b001,
      PMS_DEEP = 3'b010,
      PMS_BACKUP = 3'b011,
      PMS_CLKUP = 3'b100,
      PMS_WAKEUP = 3'b101,
      PMS_CORE_RST = 3'b110,
      PMS_SCALE = 3'b111
   } pms_state_t;

   typedef struct packed {
      logic cpu;
      logic ahb;
      logic apb;
      logic src;
      logic sysrc;
   } pms_clk_t;
endpackage

// ---- hw/pms_sequencer.sv ----
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - light sleep wakes on any qualified unmasked interrupt, back to run.
// - interrupts from modules with stopped clocks cannot wake light sleep.
// - wait/retention stop all clocks but enabled 32 kHz oscillators.
// - wait/retention keep core powered and its state retained.
// - wfi, deep sleep 1, backup 0 enters wait; hold_logic_select picks retention.
// - enabled async wake returns to run, cause recorded, wake irq if enabled.
// - backup powers core off, keeps backup domain, 32k clock, io config.
// - wfi with deep sleep 1 and backup 1 enters backup mode.
// - backup exits on brownout, watchdog, pin reset, or enabled wake.
// - backup wake sources: ext line edges, brownouts, calendar timer, watchdog.
// - slow_clk_source_sel picks crystal or rc 32 kHz for backup clocking.
// - reset exit: default level, release once supply ready, flag cause.
// - wake exit: core reset only, keep level, set backup flag, record cause.
// - light sleep wake waits source restart only if sources stopped.
// - run switch waits for regulator ready unless quick wake set.
// - wait wake restarts on system rc osc, or quick rc if selected.
// - flash forced to one wait state until regulator ready after wake.
// - level change applied at wfi, halts until stable, wakes on power ok.
module pms_sequencer #(
   parameter int SRC_WAKE_CYCLES = pms_pkg::SRC_WAKE_CYC,
   parameter int SETTLE_CYCLES = pms_pkg::SETTLE_CYC
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic WFI,
   input wire logic DEEP_SLEEP,
   input wire logic IRQ_AHB,
   input wire logic IRQ_APB,
   input wire logic IRQ_SRC,
   input wire logic IRQ_SLOW,
   input wire logic [7:0] ASYNC_WAKE,
   input wire logic [4:0] BACKUP_SELECT_BIT_WAKE,
   input wire logic [3:0] RST_SRC,
   input wire logic REG_READY,
   output pms_pkg::pms_clk_t CLK_EN,
   output logic XTAL32_RUN,
   output logic RC32_RUN,
   output logic SLOW_CLK_SEL,
   output logic CORE_PWR_ON,
   output logic CORE_RST_N,
   output logic IO_HOLD,
   output logic RETAIN,
   output logic MAIN_CLK_QUICK,
   output logic FLASH_ONE_WAIT,
   output logic [1:0] REG_LEVEL,
   output logic POWER_OK,
   output logic WAKE_IRQ
);
   initial
   begin
      if (SRC_WAKE_CYCLES < 1 || SRC_WAKE_CYCLES > 4095 || SETTLE_CYCLES < 1 || SETTLE_CYCLES > 4095)
         $error("cycle counts must lie in 1..4095");
   end

   localparam int SYNC_W = 18;
   localparam logic [11:0] SRC_WAKE_LOAD = 12'(SRC_WAKE_CYCLES);
   localparam logic [11:0] SETTLE_LOAD = 12'(SETTLE_CYCLES);

   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic [4:0] backup_select_bit_prev;
   pms_pkg::pms_state_t state;
   pms_pkg::pms_state_t next_state;
   logic [11:0] cnt;
   logic [12:0] ctrl;
   logic [7:0] wake_en;
   logic [7:0] wake_cause;
   logic [4:0] reset_cause;
   logic [4:0] deep_cause;
   logic core_rst;
   logic ack;

   // pins from outside the clock domain
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= {REG_READY, RST_SRC, BACKUP_SELECT_BIT_WAKE, ASYNC_WAKE};
         sync2 <= sync1;
      end
   end

   logic [7:0] s_async;
   logic [4:0] s_backup_select_bit;
   logic [3:0] s_rst;
   logic s_ready;
   assign s_async = sync2[7:0];
   assign s_backup_select_bit = sync2[12:8];
   assign s_rst = sync2[16:13];
   assign s_ready = sync2[17];

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         backup_select_bit_prev <= '0;
      else
         backup_select_bit_prev <= s_backup_select_bit;
   end

   logic wfi_take;
   logic rst_any;
   logic irq_wake;
   logic async_hit;
   logic [4:0] backup_select_bit_hit;
   logic [1:0] sleep_lvl;
   logic quick;
   logic bus_wr;
   assign sleep_lvl = ctrl[pms_pkg::CTRL_SLEEP_LO +: 2];
   assign quick = ctrl[pms_pkg::CTRL_QUICK_WAKE];
   assign wfi_take = WFI && state == pms_pkg::PMS_RUN;
   assign rst_any = |s_rst;
   // a stopped module cannot raise its interrupt
   assign irq_wake = (IRQ_AHB && CLK_EN.ahb) || (IRQ_APB && CLK_EN.apb) || (IRQ_SRC && CLK_EN.src) || IRQ_SLOW;
   // ext lines and calendar timer need no async enable
   assign async_hit = |(s_async & (wake_en | pms_pkg::WAKE_EXEMPT));
   // ext lines wake on transitions, the rest on level
   assign backup_select_bit_hit = {s_backup_select_bit[4:1], s_backup_select_bit[0] ^ backup_select_bit_prev[0]};
   assign bus_wr = AVS_WRITE && !AVS_WAITREQUEST;

   always_comb
   begin
      next_state = state;
      case (state)
         pms_pkg::PMS_RUN:
         begin
            if (wfi_take && DEEP_SLEEP && ctrl[pms_pkg::CTRL_BACKUP])
               next_state = pms_pkg::PMS_BACKUP;
            else if (wfi_take && DEEP_SLEEP)
               next_state = pms_pkg::PMS_DEEP;
            else if (wfi_take && ctrl[pms_pkg::CTRL_SCALE_REQ])
               next_state = pms_pkg::PMS_SCALE;
            else if (wfi_take)
               next_state = pms_pkg::PMS_SLEEP;
         end
         pms_pkg::PMS_SLEEP:
         begin
            if (irq_wake && sleep_lvl == pms_pkg::SLEEP_SRC_STOP)
               next_state = pms_pkg::PMS_CLKUP;
            else if (irq_wake)
               next_state = pms_pkg::PMS_RUN;
         end
         pms_pkg::PMS_DEEP:
         begin
            if (async_hit)
               next_state = pms_pkg::PMS_WAKEUP;
         end
         pms_pkg::PMS_BACKUP:
         begin
            if (|backup_select_bit_hit)
               next_state = pms_pkg::PMS_CORE_RST;
         end
         pms_pkg::PMS_CLKUP:
         begin
            if (cnt == '0)
               next_state = pms_pkg::PMS_RUN;
         end
         pms_pkg::PMS_WAKEUP:
         begin
            if (cnt == '0 && (s_ready || quick))
               next_state = pms_pkg::PMS_RUN;
         end
         pms_pkg::PMS_CORE_RST:
         begin
            if (cnt == '0 && s_ready)
               next_state = pms_pkg::PMS_RUN;
         end
         pms_pkg::PMS_SCALE:
         begin
            if (cnt == '0 && s_ready)
               next_state = pms_pkg::PMS_RUN;
         end
         default:
            next_state = pms_pkg::PMS_CORE_RST;
      endcase
      if (rst_any)
         next_state = pms_pkg::PMS_CORE_RST;
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         state <= pms_pkg::PMS_CORE_RST;
      else
         state <= next_state;
   end

   // restart and settle timer, loaded on entry
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         cnt <= SETTLE_LOAD;
      else if (next_state != state && next_state == pms_pkg::PMS_CLKUP)
         cnt <= SRC_WAKE_LOAD;
      else if (next_state != state && next_state == pms_pkg::PMS_WAKEUP)
         cnt <= SRC_WAKE_LOAD;
      else if (next_state != state)
         cnt <= SETTLE_LOAD;
      else if (cnt != '0)
         cnt <= cnt - 12'h001;
   end

   // core-domain reset, registered from next_state so it is in step with the state
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         core_rst <= 1'b1;
      else
         core_rst <= next_state == pms_pkg::PMS_CORE_RST || next_state == pms_pkg::PMS_BACKUP;
   end

   // backup-domain control, survives the backup-wake core reset, cleared by any reset source
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         ctrl <= pms_pkg::CTRL_RESET;
      else if (rst_any)
         ctrl <= pms_pkg::CTRL_RESET;
      else
      begin
         if (bus_wr && AVS_ADDRESS == pms_pkg::OFS_CTRL)
            ctrl <= AVS_WRITEDATA[12:0];
         if (state == pms_pkg::PMS_SCALE && next_state == pms_pkg::PMS_RUN)
            ctrl[pms_pkg::CTRL_SCALE_REQ] <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         wake_en <= '0;
      else if (core_rst)
         wake_en <= '0;
      else if (bus_wr && AVS_ADDRESS == pms_pkg::OFS_WAKE_EN)
         wake_en <= AVS_WRITEDATA[7:0];
   end

   // write one to clear; a new event wins over the clear
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         wake_cause <= '0;
      else if (core_rst)
         wake_cause <= '0;
      else
      begin
         if (bus_wr && AVS_ADDRESS == pms_pkg::OFS_WAKE_CAUSE)
            wake_cause <= wake_cause & ~AVS_WRITEDATA[7:0];
         if (state == pms_pkg::PMS_DEEP && async_hit)
            wake_cause <= s_async & (wake_en | pms_pkg::WAKE_EXEMPT);
         if (state == pms_pkg::PMS_SCALE && next_state == pms_pkg::PMS_RUN)
            wake_cause[pms_pkg::WAKE_POWER_OK_FLAG] <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         reset_cause <= '0;
      else
      begin
         if (bus_wr && AVS_ADDRESS == pms_pkg::OFS_RESET_CAUSE)
            reset_cause <= reset_cause & ~AVS_WRITEDATA[4:0];
         if (rst_any)
            reset_cause <= {1'b0, s_rst};
         else if (state == pms_pkg::PMS_BACKUP && |backup_select_bit_hit)
            reset_cause <= 5'h10;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         deep_cause <= '0;
      else
      begin
         if (bus_wr && AVS_ADDRESS == pms_pkg::OFS_DEEP_CAUSE)
            deep_cause <= deep_cause & ~AVS_WRITEDATA[4:0];
         if (state == pms_pkg::PMS_BACKUP && |backup_select_bit_hit && !rst_any)
            deep_cause <= backup_select_bit_hit;
      end
   end

   // clock gating per state
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         CLK_EN <= 5'h01;
      else
         case (next_state)
            pms_pkg::PMS_RUN:
               CLK_EN <= 5'h1F;
            pms_pkg::PMS_SLEEP, pms_pkg::PMS_SCALE:
               CLK_EN <= {1'b0, sleep_lvl < 2'h1, sleep_lvl < 2'h2, sleep_lvl < 2'h3, 1'b1};
            pms_pkg::PMS_DEEP, pms_pkg::PMS_BACKUP:
               CLK_EN <= 5'h00;
            pms_pkg::PMS_CLKUP, pms_pkg::PMS_WAKEUP:
               CLK_EN <= 5'h03;
            default:
               CLK_EN <= 5'h01;
         endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         XTAL32_RUN <= 1'b0;
         RC32_RUN <= 1'b0;
         SLOW_CLK_SEL <= 1'b0;
      end
      else
      begin
         XTAL32_RUN <= ctrl[pms_pkg::CTRL_XTAL32_EN];
         RC32_RUN <= ctrl[pms_pkg::CTRL_RC32_EN];
         SLOW_CLK_SEL <= ctrl[pms_pkg::CTRL_SLOW_SEL];
      end
   end

   // power, retention and io hold
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         CORE_PWR_ON <= 1'b1;
         CORE_RST_N <= 1'b0;
         IO_HOLD <= 1'b0;
         RETAIN <= 1'b0;
      end
      else
      begin
         CORE_PWR_ON <= next_state != pms_pkg::PMS_BACKUP;
         CORE_RST_N <= !(next_state == pms_pkg::PMS_CORE_RST || next_state == pms_pkg::PMS_BACKUP);
         IO_HOLD <= next_state == pms_pkg::PMS_BACKUP;
         RETAIN <= next_state == pms_pkg::PMS_DEEP && ctrl[pms_pkg::CTRL_HOLD_LOGIC];
      end
   end

   // wake clock, flash wait states, regulator level, power ok
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         MAIN_CLK_QUICK <= 1'b0;
         FLASH_ONE_WAIT <= 1'b1;
         REG_LEVEL <= pms_pkg::LEVEL_DEFAULT;
         POWER_OK <= 1'b0;
      end
      else
      begin
         if (next_state == pms_pkg::PMS_WAKEUP)
            MAIN_CLK_QUICK <= ctrl[pms_pkg::CTRL_WAKE_CLK];
         else if (next_state != pms_pkg::PMS_RUN)
            MAIN_CLK_QUICK <= 1'b0;
         FLASH_ONE_WAIT <= next_state == pms_pkg::PMS_WAKEUP || next_state == pms_pkg::PMS_CORE_RST
            || !s_ready || (FLASH_ONE_WAIT && !POWER_OK);
         if (rst_any)
            REG_LEVEL <= pms_pkg::LEVEL_DEFAULT;
         else if (next_state == pms_pkg::PMS_SCALE)
            REG_LEVEL <= ctrl[pms_pkg::CTRL_LEVEL_LO +: 2];
         POWER_OK <= s_ready && next_state != pms_pkg::PMS_SCALE && state != pms_pkg::PMS_SCALE
            && next_state != pms_pkg::PMS_CORE_RST;
      end
   end

   // wake interrupt pulse on return from wait or scaling
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         WAKE_IRQ <= 1'b0;
      else
         WAKE_IRQ <= ctrl[pms_pkg::CTRL_IRQ_EN] && next_state == pms_pkg::PMS_RUN
            && (state == pms_pkg::PMS_WAKEUP || state == pms_pkg::PMS_SCALE);
   end

   // bus slave: waitrequest drops for exactly one cycle per access
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ack <= 1'b0;
         AVS_WAITREQUEST <= 1'b1;
      end
      else
      begin
         ack <= (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && !ack;
         AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && !ack);
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         AVS_READDATA <= '0;
      else if (AVS_READ && AVS_WAITREQUEST)
         case (AVS_ADDRESS)
            pms_pkg::OFS_CTRL:
               AVS_READDATA <= {19'h00000, ctrl};
            pms_pkg::OFS_WAKE_EN:
               AVS_READDATA <= {24'h000000, wake_en};
            pms_pkg::OFS_WAKE_CAUSE:
               AVS_READDATA <= {24'h000000, wake_cause};
            pms_pkg::OFS_RESET_CAUSE:
               AVS_READDATA <= {27'h0000000, reset_cause};
            pms_pkg::OFS_DEEP_CAUSE:
               AVS_READDATA <= {27'h0000000, deep_cause};
            pms_pkg::OFS_STATUS:
               AVS_READDATA <= {25'h0000000, REG_LEVEL, FLASH_ONE_WAIT, state, POWER_OK};
            default:
               AVS_READDATA <= '0;
         endcase
   end

   property p_sleep_wake;
      @(posedge CLOCK) disable iff (!RST_N)
      state == pms_pkg::PMS_SLEEP && irq_wake && sleep_lvl != 2'h3 && !rst_any |=> state == pms_pkg::PMS_RUN;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("light sleep did not wake");

   property p_gated_irq;
      @(posedge CLOCK) disable iff (!RST_N)
      state == pms_pkg::PMS_SLEEP && !irq_wake && !rst_any |=> state == pms_pkg::PMS_SLEEP;
   endproperty
   a_gated_irq: assert property (p_gated_irq) else $error("sleep left without wake");

   property p_deep_clocks;
      @(posedge CLOCK) disable iff (!RST_N)
      state == pms_pkg::PMS_DEEP |-> CLK_EN == 5'h00 && CORE_PWR_ON;
   endproperty
   a_deep_clocks: assert property (p_deep_clocks) else $error("clock running in wait");

   property p_enter_backup;
      @(posedge CLOCK) disable iff (!RST_N)
      wfi_take && DEEP_SLEEP && ctrl[pms_pkg::CTRL_BACKUP] && !rst_any |=> ##1 !CORE_PWR_ON && IO_HOLD;
   endproperty
   a_enter_backup: assert property (p_enter_backup) else $error("backup entry missed");

   property p_backup_flag;
      @(posedge CLOCK) disable iff (!RST_N)
      state == pms_pkg::PMS_BACKUP && |backup_select_bit_hit && !rst_any |=> reset_cause[pms_pkg::RSTC_BACKUP] && !CORE_RST_N;
   endproperty
   a_backup_flag: assert property (p_backup_flag) else $error("backup wake not flagged");

   property p_reset_exit;
      @(posedge CLOCK) disable iff (!RST_N)
      $rose(CORE_RST_N) |-> $past(s_ready) && $past(state) == pms_pkg::PMS_CORE_RST;
   endproperty
   a_reset_exit: assert property (p_reset_exit) else $error("core reset released early");

   property p_scale_ok_low;
      @(posedge CLOCK) disable iff (!RST_N)
      state == pms_pkg::PMS_SCALE |=> !POWER_OK;
   endproperty
   a_scale_ok_low: assert property (p_scale_ok_low) else $error("power ok high while scaling");

   property p_scale_done;
      @(posedge CLOCK) disable iff (!RST_N)
      state == pms_pkg::PMS_SCALE && next_state == pms_pkg::PMS_RUN && !rst_any
         |=> wake_cause[pms_pkg::WAKE_POWER_OK_FLAG] && !ctrl[pms_pkg::CTRL_SCALE_REQ];
   endproperty
   a_scale_done: assert property (p_scale_done) else $error("scaling end not reported");

   property p_flash_wait;
      @(posedge CLOCK) disable iff (!RST_N)
      state == pms_pkg::PMS_WAKEUP |-> FLASH_ONE_WAIT;
   endproperty
   a_flash_wait: assert property (p_flash_wait) else $error("flash not slowed on wake");

   property p_quick;
      @(posedge CLOCK) disable iff (!RST_N)
      state == pms_pkg::PMS_WAKEUP && cnt == '0 && !s_ready && !quick && !rst_any |=> state == pms_pkg::PMS_WAKEUP;
   endproperty
   a_quick: assert property (p_quick) else $error("wake left before regulator ready");
endmodule // pms_sequencer

// ---- verif/power_mode_sequencer_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module power_mode_sequencer_tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic waitreq;
   logic wfi = 1'b0;
   logic deep = 1'b0;
   logic irq_ahb = 1'b0;
   logic irq_apb = 1'b0;
   logic irq_src = 1'b0;
   logic irq_slow = 1'b0;
   logic [7:0] async_wake = 8'h00;
   logic [4:0] backup_select_bit_wake = 5'h00;
   logic [3:0] rst_src = 4'h0;
   logic reg_ready = 1'b1;
   pms_pkg::pms_clk_t clk_en;
   logic xtal32_run, rc32_run, slow_sel, core_pwr_on, core_rst_n, io_hold, retain;
   logic main_quick, flash_one, power_ok, wake_irq;
   logic [1:0] reg_level;
   logic [31:0] q;
   int failures = 0;
   int checks = 0;
   int cyc = 0;

   pms_sequencer #(.SRC_WAKE_CYCLES(3), .SETTLE_CYCLES(5)) i_dut (
      .CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .WFI(wfi),
      .DEEP_SLEEP(deep), .IRQ_AHB(irq_ahb), .IRQ_APB(irq_apb), .IRQ_SRC(irq_src),
      .IRQ_SLOW(irq_slow), .ASYNC_WAKE(async_wake), .BACKUP_SELECT_BIT_WAKE(backup_select_bit_wake), .RST_SRC(rst_src),
      .REG_READY(reg_ready), .CLK_EN(clk_en), .XTAL32_RUN(xtal32_run), .RC32_RUN(rc32_run),
      .SLOW_CLK_SEL(slow_sel), .CORE_PWR_ON(core_pwr_on), .CORE_RST_N(core_rst_n),
      .IO_HOLD(io_hold), .RETAIN(retain), .MAIN_CLK_QUICK(main_quick),
      .FLASH_ONE_WAIT(flash_one), .REG_LEVEL(reg_level), .POWER_OK(power_ok), .WAKE_IRQ(wake_irq)
   );

   always #5 clock = ~clock;

   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do
         @(posedge clock);
      while (waitreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic issue_wfi(input logic d);
      @(posedge clock);
      wfi <= 1'b1;
      deep <= d;
      @(posedge clock);
      wfi <= 1'b0;
      cycles(3);
   endtask

   task automatic wait_core_up();
      int n;
      n = 0;
      while (core_rst_n !== 1'b1 && n < 200)
      begin
         @(negedge clock);
         n++;
      end
      cycles(2);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (wake_irq !== 1'b1 && n < 200)
      begin
         @(negedge clock);
         n++;
      end
      `CHK("wake_irq", 1'b1, wake_irq)
   endtask

   task automatic t_light_sleep();
      bus(1'b1, pms_pkg::OFS_CTRL, 32'h0000_0100);
      issue_wfi(1'b0);
      `CHK("sleep cpu clk", 1'b0, clk_en.cpu)
      `CHK("sleep ahb clk", 1'b0, clk_en.ahb)
      @(posedge clock);
      irq_ahb <= 1'b1;
      cycles(6);
      `CHK("gated irq no wake", 1'b0, clk_en.cpu)
      @(posedge clock);
      irq_apb <= 1'b1;
      cycles(3);
      `CHK("irq wake cpu clk", 1'b1, clk_en.cpu)
      @(posedge clock);
      irq_ahb <= 1'b0;
      irq_apb <= 1'b0;
      bus(1'b0, pms_pkg::OFS_STATUS, 32'h0);
      `CHK("state after sleep", pms_pkg::PMS_RUN, q[3:1])
      // sources stopped: wake goes through the restart count
      bus(1'b1, pms_pkg::OFS_CTRL, 32'h0000_0300);
      issue_wfi(1'b0);
      @(posedge clock);
      irq_slow <= 1'b1;
      cycles(2);
      `CHK("source restart", 5'h03, clk_en)
      cycles(4);
      `CHK("restart done", 5'h1F, clk_en)
      @(posedge clock);
      irq_slow <= 1'b0;
   endtask

   task automatic t_wait_mode();
      int n;
      bus(1'b1, pms_pkg::OFS_WAKE_EN, 32'h0000_0000);
      bus(1'b1, pms_pkg::OFS_CTRL, 32'h0000_1412);
      issue_wfi(1'b1);
      `CHK("wait clocks", 5'h00, clk_en)
      `CHK("xtal32 kept", 1'b1, xtal32_run)
      `CHK("rc32 off", 1'b0, rc32_run)
      `CHK("core powered", 1'b1, core_pwr_on)
      `CHK("retention", 1'b1, retain)
      @(posedge clock);
      async_wake <= 8'h04;
      cycles(8);
      `CHK("disabled source", 5'h00, clk_en)
      @(posedge clock);
      async_wake <= 8'h01;
      reg_ready <= 1'b0;
      n = 0;
      while (clk_en === 5'h00 && n < 50)
      begin
         @(negedge clock);
         n++;
      end
      `CHK("quick rc", 1'b1, main_quick)
      `CHK("flash one wait", 1'b1, flash_one)
      cycles(10);
      `CHK("held for regulator", 5'h03, clk_en)
      @(posedge clock);
      reg_ready <= 1'b1;
      wait_irq();
      `CHK("quick rc kept", 1'b1, main_quick)
      @(posedge clock);
      async_wake <= 8'h00;
      cycles(2);
      `CHK("run clocks", 5'h1F, clk_en)
      bus(1'b0, pms_pkg::OFS_WAKE_CAUSE, 32'h0);
      `CHK("wake cause", 32'h0000_0001, q)
      bus(1'b1, pms_pkg::OFS_WAKE_CAUSE, 32'h0000_00FF);
   endtask

   task automatic t_backup();
      // ext line high before entry: a steady level must not wake
      backup_select_bit_wake <= 5'h01;
      bus(1'b1, pms_pkg::OFS_CTRL, 32'h0000_0009);
      issue_wfi(1'b1);
      `CHK("core off", 1'b0, core_pwr_on)
      `CHK("io held", 1'b1, io_hold)
      `CHK("slow sel", 1'b1, slow_sel)
      cycles(10);
      `CHK("level ext no edge", 1'b0, core_pwr_on)
      @(posedge clock);
      backup_select_bit_wake <= 5'h09;
      wait_core_up();
      `CHK("core back", 1'b1, core_pwr_on)
      @(posedge clock);
      backup_select_bit_wake <= 5'h00;
      bus(1'b0, pms_pkg::OFS_RESET_CAUSE, 32'h0);
      `CHK("backup flag", 32'h0000_0010, q)
      bus(1'b0, pms_pkg::OFS_DEEP_CAUSE, 32'h0);
      `CHK("deep wake cause", 32'h0000_0008, q)
      bus(1'b1, pms_pkg::OFS_RESET_CAUSE, 32'h0000_001F);
      bus(1'b1, pms_pkg::OFS_DEEP_CAUSE, 32'h0000_001F);
   endtask

   task automatic t_scale();
      bus(1'b1, pms_pkg::OFS_CTRL, 32'h0000_10A0);
      reg_ready <= 1'b0;
      issue_wfi(1'b0);
      `CHK("level applied", 2'h1, reg_level)
      `CHK("power ok low", 1'b0, power_ok)
      cycles(12);
      `CHK("power ok held", 1'b0, power_ok)
      `CHK("flash while unready", 1'b1, flash_one)
      @(posedge clock);
      reg_ready <= 1'b1;
      wait_irq();
      cycles(1);
      `CHK("power ok up", 1'b1, power_ok)
      bus(1'b0, pms_pkg::OFS_WAKE_CAUSE, 32'h0);
      `CHK("power ok cause", 32'h0000_0080, q)
      bus(1'b0, pms_pkg::OFS_CTRL, 32'h0);
      `CHK("request cleared", 32'h0000_1020, q)
   endtask

   task automatic t_reset_source();
      rst_src <= 4'h4;
      cycles(6);
      @(posedge clock);
      rst_src <= 4'h0;
      wait_core_up();
      `CHK("default level", 2'h0, reg_level)
      bus(1'b0, pms_pkg::OFS_RESET_CAUSE, 32'h0);
      `CHK("reset cause", 32'h0000_0004, q)
      bus(1'b0, pms_pkg::OFS_CTRL, 32'h0);
      `CHK("ctrl after reset", 32'h0000_0000, q)
      bus(1'b0, 8'h40, 32'h0);
      `CHK("unmapped read", 32'h0000_0000, q)
   endtask

   initial
   begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      wait_core_up();
      `CHK("reset clocks", 5'h1F, clk_en)
      bus(1'b0, pms_pkg::OFS_CTRL, 32'h0);
      `CHK("ctrl reset", 32'h0000_0000, q)
      t_light_sleep();
      t_wait_mode();
      t_backup();
      t_scale();
      t_reset_source();
      finish_test();
   end
endmodule // power_mode_sequencer_tb
